// File: hdl/seq_defines.svh
// offsets, field positions, reset values and timing counts of the slot sequencer
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH
// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define SEQ_CLK_HZ 25000000
`define SEQ_SAMPLE_CLK_HZ 32000
`define SEQ_TICK_DIV (`SEQ_CLK_HZ / `SEQ_SAMPLE_CLK_HZ)
`define SEQ_US_CYCLES (`SEQ_CLK_HZ / 1000000)
`define SEQ_OFFSET_MIN_US 23
`define SEQ_OFFSET_MAX_US 63
`define SEQ_PERIOD_MIN_US 19
`define SEQ_PERIOD_MAX_US 63
`define SEQ_CMP_A_US 68
`define SEQ_CMP_B_US 20
`define SEQ_SLEEP_MIN_US 222
`define SEQ_SLEEP_CYCLES (`SEQ_SLEEP_MIN_US * `SEQ_US_CYCLES)
`define SEQ_TRIM_NOMINAL 6'h12
// ------------------------------------------------------------
// device register offsets
// ------------------------------------------------------------
`define SEQ_ADDR_MODE 8'h10
`define SEQ_ADDR_SLOT_EN 8'h11
`define SEQ_ADDR_RATE 8'h12
`define SEQ_ADDR_SWITCH 8'h14
`define SEQ_ADDR_A_OFF 8'h30
`define SEQ_ADDR_A_PER 8'h31
`define SEQ_ADDR_B_OFF 8'h35
`define SEQ_ADDR_B_PER 8'h36
`define SEQ_ADDR_B_CFG 8'h38
`define SEQ_ADDR_TUNE 8'h4b
`define SEQ_ADDR_PIN_CFG 8'h4f
// ------------------------------------------------------------
// field positions and codes
// ------------------------------------------------------------
`define SEQ_MODE_HI 1
`define SEQ_MODE_LO 0
`define SEQ_SEL_B_HI 11
`define SEQ_SEL_B_LO 8
`define SEQ_SEL_A_HI 7
`define SEQ_SEL_A_LO 4
`define SEQ_COUNT_HI 15
`define SEQ_COUNT_LO 8
`define SEQ_TIME_HI 7
`define SEQ_TIME_LO 0
`define SEQ_TRIM_HI 5
`define SEQ_TRIM_LO 0
`define SEQ_CLKSRC_HI 8
`define SEQ_CLKSRC_LO 7
`define SEQ_SYNC_HI 3
`define SEQ_SYNC_LO 2
`define SEQ_PIN0_EN 1
`define SEQ_PIN1_EN 5
`define SEQ_EN_A 0
`define SEQ_EN_B 1
`define SEQ_MODE_STANDBY 2'h0
`define SEQ_MODE_PROGRAM 2'h1
`define SEQ_MODE_NORMAL 2'h2
`define SEQ_CLKSRC_EXT 2'h2
`define SEQ_SYNC_PIN0 2'h1
`define SEQ_SYNC_PIN1 2'h2
`define SEQ_PD_FLOAT 4'h0
`define SEQ_PD_ALL 4'h1
`define SEQ_PD_UPPER 4'h4
`define SEQ_PD_LOWER 4'h5
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SEQ_RST_MODE 16'h0000
`define SEQ_RST_SLOT_EN 16'h0003
`define SEQ_RST_RATE 16'h0008
`define SEQ_RST_SWITCH 16'h0000
`define SEQ_RST_OFF 16'h0017
`define SEQ_RST_PER 16'h0113
`define SEQ_RST_B_CFG 16'h0000
`define SEQ_RST_TUNE 16'h2612
`define SEQ_RST_PIN_CFG 16'h0000
// ------------------------------------------------------------
// host register offsets and control bits
// ------------------------------------------------------------
`define HOST_ADDR_TARGET 8'h00
`define HOST_ADDR_WDATA 8'h04
`define HOST_ADDR_CTRL 8'h08
`define HOST_ADDR_STATUS 8'h0c
`define HOST_ADDR_PINS 8'h10
`define HOST_CTRL_WRITE 0
`define HOST_CTRL_READ 1
`endif

// File: hdl/seq_pkg.sv
// state types of the slot sequencer and its host end
package seq_pkg;
  typedef enum logic [8:0] {
    ST_READY = 9'b000000001,
    ST_SYNC  = 9'b000000010,
    ST_A_OFF = 9'b000000100,
    ST_A_PUL = 9'b000001000,
    ST_A_CMP = 9'b000010000,
    ST_B_OFF = 9'b000100000,
    ST_B_PUL = 9'b001000000,
    ST_B_CMP = 9'b010000000,
    ST_SLEEP = 9'b100000000
  } seq_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b01,
    H_WAIT = 2'b10
  } host_state_t;

  typedef struct packed {
    seq_state_t st;
    logic [1:0] mode;
    logic [1:0] slot_en;
    logic [15:0] rate;
    logic [15:0] sw;
    logic [15:0] a_off;
    logic [15:0] a_per;
    logic [15:0] b_off;
    logic [15:0] b_per;
    logic [15:0] b_cfg;
    logic [15:0] tune;
    logic [15:0] pin_cfg;
    logic [15:0] rdata;
    logic ack;
    logic [9:0] div;
    logic [15:0] per_cnt;
    logic [23:0] cyc;
    logic [7:0] pulses;
    logic pend;
    logic pend_ext;
    logic [1:0] sync_ticks;
    logic [2:0] s0;
    logic [2:0] s1;
    logic led;
    logic start;
    logic act_a;
    logic act_b;
    logic [7:0] pd;
  } dev_reg_t;

  typedef struct packed {
    host_state_t st;
    logic [7:0] tgt;
    logic [15:0] wdat;
    logic [15:0] rdat;
    logic wr;
    logic rd;
    logic avwait;
    logic [31:0] avrdata;
    logic [1:0] pin_lvl;
    logic [1:0] pin_oe_n;
  } host_reg_t;
endpackage

// File: hdl/sense_link_if.sv
// register port and general pins between host end and sequencer
`timescale 1ns/1ps
interface sense_link_if;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic reg_ack;
  logic pin0_o;
  logic pin0_oe_n;
  logic pin1_o;
  logic pin1_oe_n;
  logic general_pin_zero;
  logic general_pin_one;

  // undriven pin reads low
  assign general_pin_zero = pin0_oe_n ? 1'b0 : pin0_o;
  assign general_pin_one = pin1_oe_n ? 1'b0 : pin1_o;

  modport dev (
    input reg_wr, reg_rd, reg_addr, reg_wdata, general_pin_zero, general_pin_one,
    output reg_rdata, reg_ack
  );
  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata, pin0_o, pin0_oe_n, pin1_o, pin1_oe_n,
    input reg_rdata, reg_ack
  );
endinterface

// File: hdl/slot_sequencer.sv
// two-slot optical sample sequencer with its register file
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "seq_defines.svh"
module slot_sequencer #(
  parameter int SLEEP_CYCLES = `SEQ_SLEEP_CYCLES,
  parameter bit EIGHT_INPUT = 1'b1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // link to the host end
  sense_link_if.dev link,
  // front end controls
  output logic [7:0] pd_connect,
  output logic led_strobe,
  output logic slot_a_active,
  output logic slot_b_active,
  output logic sample_start,
  output logic [1:0] op_mode
);
  localparam logic [23:0] SLEEP_LOAD = 24'(SLEEP_CYCLES - 1);

  if (SLEEP_CYCLES < 1 || SLEEP_CYCLES > 24'hffffff)
  begin : g_bad_sleep
    $error("sleep count out of range");
  end

  seq_pkg::dev_reg_t q;
  seq_pkg::dev_reg_t n;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [23:0] us_load(input logic [7:0] us, input logic [7:0] floor_us);
    logic [7:0] v;
    v = (us < floor_us) ? floor_us : us;
    return (24'(v) * 24'(`SEQ_US_CYCLES)) - 24'h000001;
  endfunction

  function automatic logic [7:0] pd_map(input logic [3:0] code);
    logic [7:0] m;
    m = 8'h00;
    if (EIGHT_INPUT)
    begin
      case (code)
        `SEQ_PD_ALL: m = 8'hff;
        `SEQ_PD_UPPER: m = 8'hf0;
        `SEQ_PD_LOWER: m = 8'h0f;
        default: m = 8'h00;
      endcase
    end
    else
    begin
      case (code)
        `SEQ_PD_ALL: m = 8'h21;
        `SEQ_PD_LOWER: m = 8'hc3;
        default: m = 8'h00;
      endcase
    end
    return m;
  endfunction

  logic rise0;
  logic rise1;
  logic ext_clk;
  logic tick;
  logic [9:0] div_load;
  logic ext_edge;
  logic normal;

  always_comb
  begin
    n = q;
    n.ack = 1'b0;
    n.led = 1'b0;
    n.start = 1'b0;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    n.s0 = {q.s0[1:0], link.general_pin_zero};
    n.s1 = {q.s1[1:0], link.general_pin_one};
    rise0 = q.s0[1] & ~q.s0[2];
    rise1 = q.s1[1] & ~q.s1[2];

    // ------------------------------------------------------------
    // sample clock tick
    // ------------------------------------------------------------
    // external clock select
    ext_clk = (q.tune[`SEQ_CLKSRC_HI:`SEQ_CLKSRC_LO] == `SEQ_CLKSRC_EXT);
    div_load = 10'(`SEQ_TICK_DIV) + 10'(q.tune[`SEQ_TRIM_HI:`SEQ_TRIM_LO]) - 10'(`SEQ_TRIM_NOMINAL);
    if (ext_clk)
    begin
      n.div = 10'h000;
      tick = rise1;
    end
    else
    begin
      tick = (q.div == 10'h000);
      n.div = tick ? (div_load - 10'h001) : (q.div - 10'h001);
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    n.ack = link.reg_wr | link.reg_rd;
    if (link.reg_wr)
    begin
      if (link.reg_addr == `SEQ_ADDR_MODE)
        n.mode = link.reg_wdata[`SEQ_MODE_HI:`SEQ_MODE_LO];
      else if (link.reg_addr == `SEQ_ADDR_SLOT_EN)
        n.slot_en = link.reg_wdata[1:0];
      else if (link.reg_addr == `SEQ_ADDR_RATE)
        n.rate = link.reg_wdata;
      else if (link.reg_addr == `SEQ_ADDR_SWITCH)
        n.sw = link.reg_wdata;
      else if (link.reg_addr == `SEQ_ADDR_A_OFF)
        n.a_off = link.reg_wdata;
      else if (link.reg_addr == `SEQ_ADDR_A_PER)
        n.a_per = link.reg_wdata;
      else if (link.reg_addr == `SEQ_ADDR_B_OFF)
        n.b_off = link.reg_wdata;
      else if (link.reg_addr == `SEQ_ADDR_B_PER)
        n.b_per = link.reg_wdata;
      else if (link.reg_addr == `SEQ_ADDR_B_CFG)
        n.b_cfg = link.reg_wdata;
      else if (link.reg_addr == `SEQ_ADDR_TUNE)
        n.tune = link.reg_wdata;
      else if (link.reg_addr == `SEQ_ADDR_PIN_CFG)
        n.pin_cfg = link.reg_wdata;
    end
    if (link.reg_addr == `SEQ_ADDR_MODE)
      n.rdata = {14'h0000, q.mode};
    else if (link.reg_addr == `SEQ_ADDR_SLOT_EN)
      n.rdata = {14'h0000, q.slot_en};
    else if (link.reg_addr == `SEQ_ADDR_RATE)
      n.rdata = q.rate;
    else if (link.reg_addr == `SEQ_ADDR_SWITCH)
      n.rdata = q.sw;
    else if (link.reg_addr == `SEQ_ADDR_A_OFF)
      n.rdata = q.a_off;
    else if (link.reg_addr == `SEQ_ADDR_A_PER)
      n.rdata = q.a_per;
    else if (link.reg_addr == `SEQ_ADDR_B_OFF)
      n.rdata = q.b_off;
    else if (link.reg_addr == `SEQ_ADDR_B_PER)
      n.rdata = q.b_per;
    else if (link.reg_addr == `SEQ_ADDR_B_CFG)
      n.rdata = q.b_cfg;
    else if (link.reg_addr == `SEQ_ADDR_TUNE)
      n.rdata = q.tune;
    else if (link.reg_addr == `SEQ_ADDR_PIN_CFG)
      n.rdata = q.pin_cfg;
    else
      n.rdata = 16'h0000;

    // ------------------------------------------------------------
    // sample triggers
    // ------------------------------------------------------------
    // only normal mode samples
    normal = (q.mode == `SEQ_MODE_NORMAL);
    ext_edge = ((q.pin_cfg[`SEQ_SYNC_HI:`SEQ_SYNC_LO] == `SEQ_SYNC_PIN0) & q.pin_cfg[`SEQ_PIN0_EN] & rise0)
             | ((q.pin_cfg[`SEQ_SYNC_HI:`SEQ_SYNC_LO] == `SEQ_SYNC_PIN1) & q.pin_cfg[`SEQ_PIN1_EN] & rise1);
    if (q.cyc != 24'h000000)
      n.cyc = q.cyc - 24'h000001;

    // ------------------------------------------------------------
    // slot sequence
    // ------------------------------------------------------------
    case (q.st)
      seq_pkg::ST_READY:
      begin
        if (normal && q.pend)
        begin
          n.pend = 1'b0;
          n.pend_ext = 1'b0;
          n.sync_ticks = 2'h2;
          n.st = q.pend_ext ? seq_pkg::ST_SYNC : seq_pkg::ST_A_OFF;
        end
      end
      seq_pkg::ST_SYNC:
      begin
        if (tick)
        begin
          n.sync_ticks = q.sync_ticks - 2'h1;
          if (q.sync_ticks == 2'h1)
            n.st = seq_pkg::ST_A_OFF;
        end
      end
      seq_pkg::ST_A_OFF:
      begin
        if (q.cyc == 24'h000000)
        begin
          n.led = 1'b1;
          n.pulses = (q.a_per[`SEQ_COUNT_HI:`SEQ_COUNT_LO] == 8'h00) ? 8'h01 : q.a_per[`SEQ_COUNT_HI:`SEQ_COUNT_LO];
          n.cyc = us_load(q.a_per[`SEQ_TIME_HI:`SEQ_TIME_LO], 8'(`SEQ_PERIOD_MIN_US));
          n.st = seq_pkg::ST_A_PUL;
        end
      end
      seq_pkg::ST_A_PUL:
      begin
        if (q.cyc == 24'h000000)
        begin
          n.pulses = q.pulses - 8'h01;
          if (q.pulses == 8'h01)
          begin
            n.cyc = us_load(8'(`SEQ_CMP_A_US), 8'h01);
            n.st = seq_pkg::ST_A_CMP;
          end
          else
          begin
            n.led = 1'b1;
            n.cyc = us_load(q.a_per[`SEQ_TIME_HI:`SEQ_TIME_LO], 8'(`SEQ_PERIOD_MIN_US));
          end
        end
      end
      seq_pkg::ST_A_CMP:
      begin
        if (q.cyc == 24'h000000)
          n.st = seq_pkg::ST_B_OFF;
      end
      seq_pkg::ST_B_OFF:
      begin
        if (q.cyc == 24'h000000)
        begin
          n.led = 1'b1;
          n.pulses = (q.b_per[`SEQ_COUNT_HI:`SEQ_COUNT_LO] == 8'h00) ? 8'h01 : q.b_per[`SEQ_COUNT_HI:`SEQ_COUNT_LO];
          n.cyc = us_load(q.b_per[`SEQ_TIME_HI:`SEQ_TIME_LO], 8'(`SEQ_PERIOD_MIN_US));
          n.st = seq_pkg::ST_B_PUL;
        end
      end
      seq_pkg::ST_B_PUL:
      begin
        if (q.cyc == 24'h000000)
        begin
          n.pulses = q.pulses - 8'h01;
          if (q.pulses == 8'h01)
          begin
            n.cyc = us_load(8'(`SEQ_CMP_B_US), 8'h01);
            n.st = seq_pkg::ST_B_CMP;
          end
          else
          begin
            n.led = 1'b1;
            n.cyc = us_load(q.b_per[`SEQ_TIME_HI:`SEQ_TIME_LO], 8'(`SEQ_PERIOD_MIN_US));
          end
        end
      end
      seq_pkg::ST_B_CMP:
      begin
        if (q.cyc == 24'h000000)
        begin
          n.cyc = SLEEP_LOAD;
          n.st = seq_pkg::ST_SLEEP;
        end
      end
      seq_pkg::ST_SLEEP:
      begin
        if (q.cyc == 24'h000000)
          n.st = seq_pkg::ST_READY;
      end
      default:
        n.st = seq_pkg::ST_READY;
    endcase

    // new trigger after the case so it wins over the consuming clear
    if (q.pin_cfg[`SEQ_SYNC_HI:`SEQ_SYNC_LO] == 2'h0)
    begin
      // rate register sets period in ticks
      if (normal && tick)
      begin
        if (q.per_cnt <= 16'h0001)
        begin
          n.per_cnt = (q.rate == 16'h0000) ? 16'h0001 : q.rate;
          n.pend = 1'b1;
        end
        else
          n.per_cnt = q.per_cnt - 16'h0001;
      end
    end
    else if (normal && ext_edge)
    begin
      n.pend = 1'b1;
      n.pend_ext = 1'b1;
    end

    if (n.st == seq_pkg::ST_A_OFF && q.st != seq_pkg::ST_A_OFF && !q.slot_en[`SEQ_EN_A])
      n.st = seq_pkg::ST_B_OFF;
    if (n.st == seq_pkg::ST_B_OFF && q.st != seq_pkg::ST_B_OFF && !q.slot_en[`SEQ_EN_B])
    begin
      n.st = seq_pkg::ST_SLEEP;
      n.cyc = SLEEP_LOAD;
    end
    // offset from slot start, floor enforced
    if (n.st == seq_pkg::ST_A_OFF && q.st != seq_pkg::ST_A_OFF)
    begin
      n.start = 1'b1;
      n.cyc = us_load(q.a_off[`SEQ_TIME_HI:`SEQ_TIME_LO], 8'(`SEQ_OFFSET_MIN_US));
    end
    if (n.st == seq_pkg::ST_B_OFF && q.st != seq_pkg::ST_B_OFF)
    begin
      n.start = (q.st != seq_pkg::ST_A_CMP);
      n.cyc = us_load(q.b_off[`SEQ_TIME_HI:`SEQ_TIME_LO], 8'(`SEQ_OFFSET_MIN_US));
    end
    // leaving normal stops sampling, registers kept
    if (!normal)
    begin
      n.st = seq_pkg::ST_READY;
      n.pend = 1'b0;
      n.pend_ext = 1'b0;
      n.led = 1'b0;
      n.start = 1'b0;
      n.per_cnt = 16'h0000;
    end

    n.act_a = (n.st == seq_pkg::ST_A_OFF) || (n.st == seq_pkg::ST_A_PUL);
    n.act_b = (n.st == seq_pkg::ST_B_OFF) || (n.st == seq_pkg::ST_B_PUL);
    n.pd = n.act_a ? pd_map(q.sw[`SEQ_SEL_A_HI:`SEQ_SEL_A_LO])
         : n.act_b ? pd_map(q.sw[`SEQ_SEL_B_HI:`SEQ_SEL_B_LO]) : 8'h00;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.st <= seq_pkg::ST_READY;
      q.mode <= 2'(`SEQ_RST_MODE);
      q.slot_en <= 2'(`SEQ_RST_SLOT_EN);
      q.rate <= `SEQ_RST_RATE;
      q.sw <= `SEQ_RST_SWITCH;
      q.a_off <= `SEQ_RST_OFF;
      q.a_per <= `SEQ_RST_PER;
      q.b_off <= `SEQ_RST_OFF;
      q.b_per <= `SEQ_RST_PER;
      q.b_cfg <= `SEQ_RST_B_CFG;
      q.tune <= `SEQ_RST_TUNE;
      q.pin_cfg <= `SEQ_RST_PIN_CFG;
    end
    else
      q <= n;
  end

  assign link.reg_rdata = q.rdata;
  assign link.reg_ack = q.ack;
  assign pd_connect = q.pd;
  assign led_strobe = q.led;
  assign slot_a_active = q.act_a;
  assign slot_b_active = q.act_b;
  assign sample_start = q.start;
  assign op_mode = q.mode;
endmodule

// File: hdl/sequencer_host.sv
// host end: Avalon-MM slave that drives the sequencer register port and pins
`timescale 1ns/1ps
`include "seq_defines.svh"
module sequencer_host (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // avalon slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // link to the sequencer
  sense_link_if.host link
);
  seq_pkg::host_reg_t q;
  seq_pkg::host_reg_t n;
  logic take;
  logic busy;

  always_comb
  begin
    n = q;
    n.wr = 1'b0;
    n.rd = 1'b0;
    n.avwait = 1'b1;
    busy = (q.st != seq_pkg::H_IDLE);
    // ------------------------------------------------------------
    // avalon access, answered one cycle after sampling
    // ------------------------------------------------------------
    take = (avs_read | avs_write) & ~q.avwait;
    if ((avs_read | avs_write) && q.avwait)
    begin
      n.avwait = 1'b0;
      if (avs_address == `HOST_ADDR_TARGET)
        n.avrdata = {24'h000000, q.tgt};
      else if (avs_address == `HOST_ADDR_WDATA)
        n.avrdata = {16'h0000, q.wdat};
      else if (avs_address == `HOST_ADDR_STATUS)
        n.avrdata = {q.rdat, 15'h0000, busy};
      else if (avs_address == `HOST_ADDR_PINS)
        n.avrdata = {28'h0000000, q.pin_oe_n, q.pin_lvl};
      else
        n.avrdata = 32'h00000000;
    end
    if (take && avs_write)
    begin
      if (avs_address == `HOST_ADDR_TARGET)
        n.tgt = avs_writedata[7:0];
      else if (avs_address == `HOST_ADDR_WDATA)
        n.wdat = avs_writedata[15:0];
      else if (avs_address == `HOST_ADDR_PINS)
      begin
        // pin driven before device input enabled
        n.pin_lvl = avs_writedata[1:0];
        n.pin_oe_n = avs_writedata[3:2];
      end
      else if (avs_address == `HOST_ADDR_CTRL && !busy)
      begin
        // a register write ordered while idle is one link transfer; an order given while busy is dropped
        n.wr = avs_writedata[`HOST_CTRL_WRITE];
        n.rd = avs_writedata[`HOST_CTRL_READ] & ~avs_writedata[`HOST_CTRL_WRITE];
        if (avs_writedata[`HOST_CTRL_WRITE] | avs_writedata[`HOST_CTRL_READ])
          n.st = seq_pkg::H_WAIT;
      end
    end
    // ------------------------------------------------------------
    // link transfer
    // ------------------------------------------------------------
    case (q.st)
      seq_pkg::H_IDLE:
        n.st = n.st;
      seq_pkg::H_WAIT:
      begin
        // mode writes complete in issue order
        if (link.reg_ack)
        begin
          n.rdat = link.reg_rdata;
          n.st = seq_pkg::H_IDLE;
        end
      end
      default:
        n.st = seq_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.st <= seq_pkg::H_IDLE;
      q.avwait <= 1'b1;
    end
    else
      q <= n;
  end

  assign avs_readdata = q.avrdata;
  assign avs_waitrequest = q.avwait;
  assign link.reg_wr = q.wr;
  assign link.reg_rd = q.rd;
  assign link.reg_addr = q.tgt;
  assign link.reg_wdata = q.wdat;
  assign link.pin0_o = q.pin_lvl[0];
  assign link.pin1_o = q.pin_lvl[1];
  assign link.pin0_oe_n = q.pin_oe_n[0];
  assign link.pin1_oe_n = q.pin_oe_n[1];
endmodule

// File: tb/seq_monitor.sv
// checker of link handshake and slot timing
`timescale 1ns/1ps
module seq_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // link
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic reg_ack,
  // sequencer outputs
  input wire logic led_strobe,
  input wire logic slot_a_active,
  input wire logic slot_b_active,
  input wire logic sample_start,
  input wire logic [1:0] op_mode
);
  logic [15:0] idle_q;
  logic [15:0] led_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ----------------
  // gap counters
  // ----------------
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      idle_q <= 16'hffff;
      led_q <= 16'hffff;
    end
    else
    begin
      idle_q <= (slot_a_active || slot_b_active) ? 16'h0 : idle_q + {15'h0, idle_q != 16'hffff};
      led_q <= led_strobe ? 16'h0 : led_q + {15'h0, led_q != 16'hffff};
    end
  property p_ack; reg_wr || reg_rd |=> reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("link ack missing");
  property p_cause; reg_ack |-> $past(reg_wr || reg_rd); endproperty
  a_cause: assert property (p_cause) else $error("link ack unasked");
  property p_addr; reg_ack |-> $stable(reg_addr); endproperty
  a_addr: assert property (p_addr) else $error("link address moved");
  property p_excl; !(reg_wr && reg_rd); endproperty
  a_excl: assert property (p_excl) else $error("read and write together");
  property p_idle; (op_mode != 2'h2) [*2] |-> !slot_a_active && !slot_b_active && !led_strobe; endproperty
  a_idle: assert property (p_idle) else $error("activity outside normal");
  property p_start; sample_start |-> op_mode == 2'h2 ##[0:1] (slot_a_active || slot_b_active); endproperty
  a_start: assert property (p_start) else $error("bad sample start");
  property p_led; led_strobe |-> led_q >= 16'd474 && (slot_a_active || slot_b_active); endproperty
  a_led: assert property (p_led) else $error("pulses too close");
  property p_cmp; $rose(slot_b_active) && !sample_start && !$past(sample_start) |-> idle_q inside {[16'd1695:16'd1705]}; endproperty
  a_cmp: assert property (p_cmp) else $error("slot a compute time wrong");
  property p_sleep; sample_start |-> idle_q >= 16'd518; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep too short");
endmodule

// File: tb/optical_sample_slot_sequencer_test.sv
// self-checking bench: host end and sequencer joined by the link
`timescale 1ns/1ps
`include "seq_defines.svh"
module optical_sample_slot_sequencer_test;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] pd_connect;
  logic led_strobe, slot_a_active, slot_b_active, sample_start;
  logic [1:0] op_mode;
  int miscompares = 0;
  int checked = 0;
  int seed = 32'hee7f;
  int t;
  logic [31:0] q;
  logic [7:0] off, per, cnt;
  logic [3:0] ca, cb;
  always #20 sys_clk = ~sys_clk;
  sense_link_if link ();
  sequencer_host sequencer_host_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(link.host));
  slot_sequencer #(.SLEEP_CYCLES(20), .EIGHT_INPUT(1'b1)) slot_sequencer_i (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .link(link.dev), .pd_connect(pd_connect), .led_strobe(led_strobe),
    .slot_a_active(slot_a_active), .slot_b_active(slot_b_active), .sample_start(sample_start), .op_mode(op_mode));
  seq_monitor seq_monitor_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd),
    .reg_addr(link.reg_addr), .reg_ack(link.reg_ack), .led_strobe(led_strobe), .slot_a_active(slot_a_active),
    .slot_b_active(slot_b_active), .sample_start(sample_start), .op_mode(op_mode));
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h saw %h", nm, e, s);
    end
  endtask
  task av(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 100);
    if (avs_waitrequest !== 1'b0)
      miscompares++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task dev(input logic w, input logic [7:0] a, input logic [15:0] d);
    av(1'b1, `HOST_ADDR_TARGET, {24'h0, a});
    av(1'b1, `HOST_ADDR_WDATA, {16'h0, d});
    av(1'b1, `HOST_ADDR_CTRL, w ? 32'h1 : 32'h2);
    repeat (4) @(posedge sys_clk);
    q = 32'h1;
    for (int k = 0; k < 20 && q[0] !== 1'b0; k++)
      av(1'b0, `HOST_ADDR_STATUS, 32'h0);
    if (q[0] !== 1'b0)
      miscompares++;
  endtask
  task wt(input logic ev);
    t = 0;
    do
    begin
      @(posedge sys_clk);
      t++;
    end
    while ((ev ? sample_start : led_strobe) !== 1'b1 && t < 9000);
  endtask
  function logic [7:0] grp(input logic [3:0] c);
    case (c)
      `SEQ_PD_ALL: grp = 8'hff;
      `SEQ_PD_UPPER: grp = 8'hf0;
      `SEQ_PD_LOWER: grp = 8'h0f;
      default: grp = 8'h00;
    endcase
  endfunction
  task end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #(40 * 90000);
    miscompares++;
    end_sim;
  end
  initial
  begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    dev(1'b0, `SEQ_ADDR_MODE, 16'h0);
    chk("mode", q[31:16], `SEQ_RST_MODE);
    dev(1'b0, `SEQ_ADDR_TUNE, 16'h0);
    chk("tune", q[31:16], `SEQ_RST_TUNE);
    dev(1'b0, `SEQ_ADDR_A_OFF, 16'h0);
    chk("offset", q[31:16], `SEQ_RST_OFF);
    av(1'b0, 8'h20, 32'h0);
    chk("unmapped", q, 32'h0);
    chk("op_mode", op_mode, `SEQ_MODE_STANDBY);
    $display("test reset done");
    for (int r = 0; r < 4; r++)
    begin
      off = r == 0 ? 8'd23 : 8'(23 + {$random(seed)} % 41);
      per = r == 0 ? 8'd19 : 8'(19 + {$random(seed)} % 45);
      cnt = 8'(1 + r % 2);
      ca = r == 0 ? 4'h1 : r == 1 ? 4'h4 : r == 2 ? 4'h5 : 4'h9;
      cb = 4'($random(seed));
      dev(1'b1, `SEQ_ADDR_MODE, `SEQ_MODE_PROGRAM);
      dev(1'b1, `SEQ_ADDR_A_OFF, {8'h0, off});
      dev(1'b1, `SEQ_ADDR_A_PER, {cnt, per});
      dev(1'b1, `SEQ_ADDR_B_OFF, {8'h0, off});
      dev(1'b1, `SEQ_ADDR_B_PER, {cnt, per});
      dev(1'b1, `SEQ_ADDR_SWITCH, {4'h0, cb, ca, 4'h0});
      dev(1'b1, `SEQ_ADDR_SLOT_EN, r == 3 ? 16'h2 : 16'h3);
      dev(1'b1, `SEQ_ADDR_RATE, 16'h1);
      dev(1'b0, `SEQ_ADDR_SWITCH, 16'h0);
      chk("switch", q[31:16], {16'h0, 4'h0, cb, ca, 4'h0});
      dev(1'b1, `SEQ_ADDR_MODE, `SEQ_MODE_NORMAL);
      wt(1'b1);
      chk("start", sample_start, 1'b1);
      wt(1'b0);
      chk("delay", t, off * 25);
      chk("pd", pd_connect, grp(r == 3 ? cb : ca));
      chk("slot_a", slot_a_active, r != 3);
      if (cnt > 1)
      begin
        wt(1'b0);
        chk("spacing", t, per * 25);
      end
      if (r < 3)
      begin
        wt(1'b0);
        chk("pd_b", pd_connect, grp(cb));
        chk("slot_b", slot_b_active, 1'b1);
      end
      dev(1'b1, `SEQ_ADDR_MODE, `SEQ_MODE_PROGRAM);
      // keep the sleep gap before the next sample
      repeat (600) @(posedge sys_clk);
      $display("test run %0d done", r);
    end
    // sync set up in program mode
    dev(1'b1, `SEQ_ADDR_RATE, 16'hffff);
    // pin driven before its input is enabled
    av(1'b1, `HOST_ADDR_PINS, 32'h0);
    dev(1'b1, `SEQ_ADDR_PIN_CFG, 16'h0006);
    dev(1'b1, `SEQ_ADDR_B_CFG, 16'h4000);
    dev(1'b1, `SEQ_ADDR_MODE, `SEQ_MODE_NORMAL);
    wt(1'b1);
    chk("quiet", t, 9000);
    av(1'b1, `HOST_ADDR_PINS, 32'h1);
    @(posedge sys_clk);
    chk("pin", link.general_pin_zero, 1'b1);
    wt(1'b1);
    chk("sync", t >= 770 && t <= 1600, 1'b1);
    $display("test sync done");
    end_sim;
  end
endmodule
